// ### core/timer8_pkg.sv
package timer8_pkg;
   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [7:0] IDX_CONTROL_A = 8'h24;
   localparam logic [7:0] IDX_CONTROL_B = 8'h25;
   localparam logic [7:0] IDX_COUNT     = 8'h26;
   localparam logic [7:0] IDX_COMPARE_A = 8'h27;
   localparam logic [7:0] IDX_COMPARE_B = 8'h28;
   localparam logic [7:0] IDX_IRQ_FLAGS = 8'h15;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'h6E;
   localparam int         ADDR_LSB      = 2;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int OUT_MODE_A_LSB = 6;
   localparam int OUT_MODE_B_LSB = 4;
   localparam int FORCE_A_BIT    = 7;
   localparam int FORCE_B_BIT    = 6;
   localparam int WAVE_HIGH_BIT  = 3;
   localparam int MATCH_B_BIT    = 2;
   localparam int MATCH_A_BIT    = 1;
   localparam int OVERFLOW_BIT   = 0;
   localparam logic [7:0] CTRL_A_MASK = 8'hF3;
   localparam logic [7:0] CTRL_B_MASK = 8'h0F;
   localparam logic [7:0] IRQ_MASK    = 8'h07;
   localparam logic [7:0] REG_RESET   = 8'h00;
   // ****************************************
   // Counter limits and prescaler
   // ****************************************
   localparam logic [7:0] COUNT_MAX    = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam int PRESC_WIDTH = 10;
   localparam int DIV_8    = 8;
   localparam int DIV_64   = 64;
   localparam int DIV_256  = 256;
   localparam int DIV_1024 = 1024;
   // ****************************************
   // Modes and codes
   // ****************************************
   localparam logic [2:0] MODE_NORMAL    = 3'h0;
   localparam logic [2:0] MODE_PHASE_FF  = 3'h1;
   localparam logic [2:0] MODE_CLEAR     = 3'h2;
   localparam logic [2:0] MODE_FAST_FF   = 3'h3;
   localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
   localparam logic [2:0] MODE_FAST_CMP  = 3'h7;
   localparam logic [2:0] CLK_STOP     = 3'h0;
   localparam logic [2:0] CLK_DIV1     = 3'h1;
   localparam logic [2:0] CLK_DIV8     = 3'h2;
   localparam logic [2:0] CLK_DIV64    = 3'h3;
   localparam logic [2:0] CLK_DIV256   = 3'h4;
   localparam logic [2:0] CLK_DIV1024  = 3'h5;
   localparam logic [2:0] CLK_EXT_FALL = 3'h6;
   localparam logic [2:0] CLK_EXT_RISE = 3'h7;
   localparam logic [1:0] OUT_OFF    = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLEAR  = 2'h2;
   localparam logic [1:0] OUT_SET    = 2'h3;
   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } count_dir_type;
endpackage

// ### core/timer8_waveform_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Reserved bits of control, mask and flag registers read as zero
// - Mode is high bit of control B joined to two low bits of A
// - Modes 0,1,3 top 0xFF; 2,5,7 top compare A; 4,6 reserved
// - Compare update immediate, at TOP for phase PWM and at TOP for fast PWM
// - Overflow at MAX in 0,2,3; BOTTOM in 1,5; TOP in 7
// - Force bit in non-PWM mode applies channel match action at once
// - Forced match sets no flag, never clears counter, reads zero
// - Clock codes 1..5 give undivided, /8, /64, /256, /1024 ticks
// - Code 0 stops; 6 counts pin falling edges; 7 rising edges
// - Pin edges count regardless of pin direction
// - Counter read and write; a write blocks next timer-tick match
// - Compare values compared continuously; match drives flag and pin
// - Irq needs enable, global enable and flag all set
// - Match flags set at bits 2 and 1 on compare match
// - Match flags cleared by vector execution
// - Writing one clears a flag; writing zero leaves it
// - Overflow flag bit 0, cleared by vector or writing one
// - Non-PWM: 1 toggle, 2 clear, 3 set, 0 disconnected
// - Fast PWM: 2 clears on match sets at BOTTOM; 3 inverse
// - Phase PWM: 2 clears on up match, sets on down match; 3 inverse
module timer8_waveform_ctrl
   import timer8_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        ext_count_pin_i,
   input  wire logic        global_irq_en_i,
   input  wire logic        vector_ack_a_i,
   input  wire logic        vector_ack_b_i,
   input  wire logic        vector_ack_ovf_i,
   output logic             wave_out_a_o,
   output logic             wave_out_b_o,
   output logic             wave_out_a_en_o,
   output logic             wave_out_b_en_o,
   output logic             match_a_irq_o,
   output logic             match_b_irq_o,
   output logic             overflow_irq_o
);
   // ****************************************
   // Registers and wires
   // ****************************************
   logic [7:0]            control_a_reg;
   logic [7:0]            control_b_reg;
   logic [7:0]            count_reg;
   logic [7:0]            compare_a_reg;
   logic [7:0]            compare_b_reg;
   logic [7:0]            active_a_reg;
   logic [7:0]            active_b_reg;
   logic [2:0]            flags_reg;
   logic [2:0]            mask_reg;
   logic                  block_reg;
   count_dir_type         dir_reg;
   logic [PRESC_WIDTH-1:0] presc_reg;
   logic                  pin_meta_reg;
   logic                  pin_sync_reg;
   logic                  pin_last_reg;
   logic                  wave_a_reg;
   logic                  wave_b_reg;
   logic [31:0]           prdata_reg;
   logic                  pslverr_reg;
   logic [2:0]            wave_mode;
   logic [2:0]            clock_select_field;
   logic [1:0]            out_mode_a;
   logic [1:0]            out_mode_b;
   logic                  phase_mode;
   logic                  fast_mode;
   logic                  pwm_mode;
   logic [7:0]            top;
   logic                  tick;
   logic                  at_top;
   logic                  at_bottom;
   logic                  match_a;
   logic                  match_b;
   logic                  overflow;
   logic                  wr;
   logic [7:0]            wr_idx;
   logic [7:0]            rd_idx;
   logic [7:0]            wdata;
   logic                  hit;
   logic [7:0]            rdata;
   logic                  force_a;
   logic                  force_b;

   // ****************************************
   // Mode decode
   // ****************************************
   assign wave_mode          = {control_b_reg[WAVE_HIGH_BIT], control_a_reg[1:0]};
   assign clock_select_field = control_b_reg[2:0];
   assign out_mode_a         = control_a_reg[OUT_MODE_A_LSB +: 2];
   assign out_mode_b         = control_a_reg[OUT_MODE_B_LSB +: 2];
   assign phase_mode = (wave_mode == MODE_PHASE_FF) || (wave_mode == MODE_PHASE_CMP);
   assign fast_mode  = (wave_mode == MODE_FAST_FF) || (wave_mode == MODE_FAST_CMP);
   assign pwm_mode   = phase_mode || fast_mode;
   assign top = ((wave_mode == MODE_CLEAR) || (wave_mode == MODE_PHASE_CMP) ||
                 (wave_mode == MODE_FAST_CMP)) ? active_a_reg : COUNT_MAX;
   assign at_top    = (count_reg == top);
   assign at_bottom = (count_reg == COUNT_BOTTOM);

   // ****************************************
   // Clock select and pin synchroniser
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_last_reg <= 1'b0;
      end else begin
         pin_meta_reg <= ext_count_pin_i;
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   always_comb begin
      case (clock_select_field)
         CLK_STOP:     tick = 1'b0;
         CLK_DIV1:     tick = 1'b1;
         CLK_DIV8:     tick = &presc_reg[$clog2(DIV_8)-1:0];
         CLK_DIV64:    tick = &presc_reg[$clog2(DIV_64)-1:0];
         CLK_DIV256:   tick = &presc_reg[$clog2(DIV_256)-1:0];
         CLK_DIV1024:  tick = &presc_reg[$clog2(DIV_1024)-1:0];
         CLK_EXT_FALL: tick = pin_last_reg && !pin_sync_reg;
         CLK_EXT_RISE: tick = !pin_last_reg && pin_sync_reg;
         default:      tick = 1'b0;
      endcase
   end

   // ****************************************
   // Match and overflow events
   // ****************************************
   assign match_a = tick && !block_reg && (count_reg == active_a_reg);
   assign match_b = tick && !block_reg && (count_reg == active_b_reg);
   always_comb begin
      if (phase_mode) begin
         overflow = tick && at_bottom;
      end else if (wave_mode == MODE_FAST_CMP) begin
         overflow = tick && at_top;
      end else begin
         overflow = tick && (count_reg == COUNT_MAX);
      end
   end

   // ****************************************
   // APB decode
   // ****************************************
   assign wr     = psel_i && penable_i && pwrite_i;
   assign wr_idx = (wr && hit) ? paddr_i[ADDR_LSB +: 8] : 8'hFF;
   assign rd_idx = paddr_i[ADDR_LSB +: 8];
   assign wdata  = pwdata_i[7:0];
   assign force_a = (wr_idx == IDX_CONTROL_B) && wdata[FORCE_A_BIT] && !pwm_mode;
   assign force_b = (wr_idx == IDX_CONTROL_B) && wdata[FORCE_B_BIT] && !pwm_mode;

   always_comb begin
      hit   = (paddr_i[ADDR_LSB-1:0] == '0) && (paddr_i[31:ADDR_LSB+8] == '0);
      rdata = REG_RESET;
      case (rd_idx)
         IDX_CONTROL_A: rdata = control_a_reg & CTRL_A_MASK;
         IDX_CONTROL_B: rdata = control_b_reg & CTRL_B_MASK;
         IDX_COUNT:     rdata = count_reg;
         IDX_COMPARE_A: rdata = compare_a_reg;
         IDX_COMPARE_B: rdata = compare_b_reg;
         IDX_IRQ_FLAGS: rdata = {5'h00, flags_reg};
         IDX_IRQ_MASK:  rdata = {5'h00, mask_reg};
         default:       hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (psel_i && !penable_i) begin
         prdata_reg  <= (pwrite_i || !hit) ? 32'h0000_0000 : {24'h00_0000, rdata};
         pslverr_reg <= !hit;
      end
   end

   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_reg;
   assign pslverr_o = pslverr_reg;

   // ****************************************
   // Control and compare registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         control_a_reg <= REG_RESET;
         control_b_reg <= REG_RESET;
         mask_reg      <= '0;
         compare_a_reg <= REG_RESET;
         compare_b_reg <= REG_RESET;
      end else begin
         if (wr_idx == IDX_CONTROL_A) control_a_reg <= wdata & CTRL_A_MASK;
         if (wr_idx == IDX_CONTROL_B) control_b_reg <= wdata & CTRL_B_MASK;
         if (wr_idx == IDX_IRQ_MASK)  mask_reg <= wdata[2:0];
         if (wr_idx == IDX_COMPARE_A) compare_a_reg <= wdata;
         if (wr_idx == IDX_COMPARE_B) compare_b_reg <= wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         active_a_reg <= REG_RESET;
         active_b_reg <= REG_RESET;
      end else if (!pwm_mode || (phase_mode && tick && at_top) ||
                   (fast_mode && tick && at_top)) begin
         active_a_reg <= compare_a_reg;
         active_b_reg <= compare_b_reg;
      end
   end

   // ****************************************
   // Counter
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count_reg <= COUNT_BOTTOM;
         dir_reg   <= DIR_UP;
         block_reg <= 1'b0;
      end else if (wr_idx == IDX_COUNT) begin
         count_reg <= wdata;
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
         if (phase_mode) begin
            case (dir_reg)
               DIR_UP: begin
                  if (at_top) begin
                     dir_reg   <= DIR_DOWN;
                     count_reg <= at_bottom ? count_reg : count_reg - 1'b1;
                  end else begin
                     count_reg <= count_reg + 1'b1;
                  end
               end
               DIR_DOWN: begin
                  if (at_bottom) begin
                     dir_reg   <= DIR_UP;
                     count_reg <= at_top ? count_reg : count_reg + 1'b1;
                  end else begin
                     count_reg <= count_reg - 1'b1;
                  end
               end
               default: dir_reg <= DIR_UP;
            endcase
         end else begin
            dir_reg   <= DIR_UP;
            count_reg <= at_top ? COUNT_BOTTOM : count_reg + 1'b1;
         end
      end
   end

   // ****************************************
   // Flags and interrupts
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flags_reg <= '0;
      end else begin
         if (match_b) begin
            flags_reg[MATCH_B_BIT] <= 1'b1;
         end else if (vector_ack_b_i ||
                      (wr_idx == IDX_IRQ_FLAGS && wdata[MATCH_B_BIT])) begin
            flags_reg[MATCH_B_BIT] <= 1'b0;
         end
         if (match_a) begin
            flags_reg[MATCH_A_BIT] <= 1'b1;
         end else if (vector_ack_a_i ||
                      (wr_idx == IDX_IRQ_FLAGS && wdata[MATCH_A_BIT])) begin
            flags_reg[MATCH_A_BIT] <= 1'b0;
         end
         if (overflow) begin
            flags_reg[OVERFLOW_BIT] <= 1'b1;
         end else if (vector_ack_ovf_i ||
                      (wr_idx == IDX_IRQ_FLAGS && wdata[OVERFLOW_BIT])) begin
            flags_reg[OVERFLOW_BIT] <= 1'b0;
         end
      end
   end

   assign match_b_irq_o  = global_irq_en_i && mask_reg[MATCH_B_BIT] && flags_reg[MATCH_B_BIT];
   assign match_a_irq_o  = global_irq_en_i && mask_reg[MATCH_A_BIT] && flags_reg[MATCH_A_BIT];
   assign overflow_irq_o = global_irq_en_i && mask_reg[OVERFLOW_BIT] &&
                           flags_reg[OVERFLOW_BIT];

   // ****************************************
   // Waveform generation
   // ****************************************
   function automatic logic wave_next(input logic cur, input logic [1:0] om,
                                      input logic hit_m, input logic frc,
                                      input logic tog_ok);
      logic res;
      res = cur;
      if (frc || (hit_m && !pwm_mode)) begin
         case (om)
            OUT_TOGGLE: res = !cur;
            OUT_CLEAR:  res = 1'b0;
            OUT_SET:    res = 1'b1;
            default:    res = cur;
         endcase
      end else if (fast_mode) begin
         if (tick && at_top && om[1]) begin
            res = !om[0];
         end else if (hit_m && om[1]) begin
            res = om[0];
         end else if (hit_m && om == OUT_TOGGLE && tog_ok) begin
            res = !cur;
         end
      end else if (phase_mode && hit_m) begin
         if (om[1]) begin
            res = (dir_reg == DIR_UP) ? om[0] : !om[0];
         end else if (om == OUT_TOGGLE && tog_ok) begin
            res = !cur;
         end
      end
      return res;
   endfunction

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wave_a_reg <= 1'b0;
         wave_b_reg <= 1'b0;
      end else begin
         wave_a_reg <= wave_next(wave_a_reg, out_mode_a, match_a, force_a,
                                 control_b_reg[WAVE_HIGH_BIT]);
         wave_b_reg <= wave_next(wave_b_reg, out_mode_b, match_b, force_b,
                                 1'b0);
      end
   end

   assign wave_out_a_o    = wave_a_reg;
   assign wave_out_b_o    = wave_b_reg;
   assign wave_out_a_en_o = (out_mode_a != OUT_OFF) &&
                            !(pwm_mode && out_mode_a == OUT_TOGGLE &&
                              !control_b_reg[WAVE_HIGH_BIT]);
   assign wave_out_b_en_o = (out_mode_b != OUT_OFF) &&
                            !(pwm_mode && out_mode_b == OUT_TOGGLE);

endmodule

// ### testbench/timer8_chk_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module timer8_chk
   import timer8_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        global_irq_en_i,
   input wire logic        wave_out_a_en_o,
   input wire logic        wave_out_b_en_o,
   input wire logic        match_a_irq_o,
   input wire logic        match_b_irq_o,
   input wire logic        overflow_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic acc;
   logic hit;
   logic any_irq;
   assign acc = psel_i && penable_i;
   assign any_irq = match_a_irq_o || match_b_irq_o || overflow_irq_o;
   assign hit = paddr_i[31:10] == 22'h0 && paddr_i[1:0] == 2'h0 && paddr_i[9:2] inside
      {IDX_CONTROL_A, IDX_CONTROL_B, IDX_COUNT, IDX_COMPARE_A, IDX_COMPARE_B,
       IDX_IRQ_FLAGS, IDX_IRQ_MASK};
   function automatic logic at(input logic [31:0] a, input logic [7:0] idx);
      return a == {22'h0, idx, 2'h0};
   endfunction
   property p_pin_en(logic [1:0] sel, logic en);
      logic [1:0] v;
      (acc && pwrite_i && at(paddr_i, IDX_CONTROL_A) && !pwdata_i[0], v = sel)
         |=> en == (v != 2'h0);
   endproperty
   a_ready_high: assert property (pready_o) else $error("ready dropped");
   a_read_upper_zero: assert property (acc |-> prdata_o[31:8] == 24'h0) else $error("upper bits");
   a_unmapped_error: assert property (acc && !hit |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (acc && hit |-> !pslverr_o) else $error("false error");
   a_ctrl_b_zero: assert property (acc && !pwrite_i && at(paddr_i, IDX_CONTROL_B) |->
      prdata_o[7:4] == 4'h0) else $error("control b upper bits set");
   a_mask_resv_zero: assert property (acc && !pwrite_i && at(paddr_i, IDX_IRQ_MASK) |->
      prdata_o[7:3] == 5'h0) else $error("mask reserved bits set");
   a_flag_resv_zero: assert property (acc && !pwrite_i && at(paddr_i, IDX_IRQ_FLAGS) |->
      prdata_o[7:3] == 5'h0) else $error("flag reserved bits set");
   a_pin_a_conn: assert property (p_pin_en(pwdata_i[7:6], wave_out_a_en_o))
      else $error("pin a connection wrong");
   a_pin_b_conn: assert property (p_pin_en(pwdata_i[5:4], wave_out_b_en_o))
      else $error("pin b connection wrong");
   a_irq_global: assert property (!global_irq_en_i |-> !any_irq) else $error("irq ungated");
   a_irq_mask_off: assert property (acc && pwrite_i && at(paddr_i, IDX_IRQ_MASK) &&
      pwdata_i[2:0] == 3'h0 |=> !any_irq) else $error("irq despite mask");
   c_refused: cover property (acc && pslverr_o);
   c_irq_a: cover property (match_a_irq_o);
   c_irq_ovf: cover property (overflow_irq_o);
   c_pin_b: cover property ($rose(wave_out_b_en_o));
endmodule
bind timer8_waveform_ctrl timer8_chk chk_i (.*);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import timer8_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [31:0] paddr_i = 32'h0;
   logic [31:0] pwdata_i = 32'h0;
   logic        pin = 1'b0;
   logic        gie = 1'b0;
   logic        ack_a = 1'b0;
   logic        ack_b = 1'b0;
   logic        ack_v = 1'b0;
   logic [31:0] prdata_o;
   logic [31:0] rd;
   logic        pready_o, pslverr_o, perr, wa, wb, wa_en, wb_en, irq_a, irq_b, irq_v;
   int          n_fail = 0;
   int          tests_run = 0;
   int          seed = 32'h8F6B;
   int          cnt;
   int          mdl [6];
   logic [7:0]  ridx [7] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_COUNT, IDX_COMPARE_A,
                             IDX_COMPARE_B, IDX_IRQ_MASK, IDX_IRQ_FLAGS};
   int          wmsk [6] = '{255, 8'h38, 255, 255, 255, 255};
   int          rmsk [6] = '{8'hF3, 8'h0F, 255, 255, 255, 8'h07};
   int          pma [4] = '{8'h23, 8'h21, 8'h23, 8'h21};
   int          pmb [4] = '{8'h01, 8'h01, 8'h09, 8'h09};
   int          pca [4] = '{8'h80, 8'h80, 8'h3F, 8'h3F};
   int          pcb [4] = '{8'h40, 8'h40, 8'h10, 8'h10};
   int          per [4] = '{256, 510, 64, 126};
   int          ex [4] = '{65, 128, 17, 32};
   int          dv [4] = '{DIV_8, DIV_64, DIV_256, DIV_1024};
   logic [1:0]  fc [5] = '{2'h2, 2'h1, 2'h2, 2'h3, 2'h1};
   logic        fe [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   always #5 clk_i = ~clk_i;
   timer8_waveform_ctrl uut (
      .clk_i            (clk_i),
      .reset_i          (reset_i),
      .psel_i           (psel_i),
      .penable_i        (penable_i),
      .pwrite_i         (pwrite_i),
      .paddr_i          (paddr_i),
      .pwdata_i         (pwdata_i),
      .prdata_o         (prdata_o),
      .pready_o         (pready_o),
      .pslverr_o        (pslverr_o),
      .ext_count_pin_i  (pin),
      .global_irq_en_i  (gie),
      .vector_ack_a_i   (ack_a),
      .vector_ack_b_i   (ack_b),
      .vector_ack_ovf_i (ack_v),
      .wave_out_a_o     (wa),
      .wave_out_b_o     (wb),
      .wave_out_a_en_o  (wa_en),
      .wave_out_b_en_o  (wb_en),
      .match_a_irq_o    (irq_a),
      .match_b_irq_o    (irq_b),
      .overflow_irq_o   (irq_v)
   );
   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      tests_run++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: got %h, want %h..%h", $time, g, lo, hi);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {22'h0, idx, 2'h0};
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      perr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi);
      apb(1'b0, idx, 32'h0);
      chk(rd, lo, hi);
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      print_verdict();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rdc(ridx[i], 0, 0);
      end
      wr(8'h30, 32'hFF);
      rdc(8'h30, 0, 0);
      chk(perr, 1, 1);
      repeat (3) begin
         for (int i = 0; i < 6; i++) begin
            mdl[i] = $random(seed) & wmsk[i];
            wr(ridx[i], mdl[i]);
         end
         for (int i = 0; i < 6; i++) begin
            rdc(ridx[i], mdl[i] & rmsk[i], mdl[i] & rmsk[i]);
         end
      end
      wr(IDX_CONTROL_A, 0);
      wr(IDX_IRQ_MASK, 7);
      wr(IDX_COMPARE_A, 8'h10);
      wr(IDX_COMPARE_B, 8'h80);
      wr(IDX_COUNT, 0);
      wr(IDX_CONTROL_B, CLK_DIV1);
      repeat (64) @(posedge clk_i);
      wr(IDX_CONTROL_B, CLK_STOP);
      rdc(IDX_IRQ_FLAGS, 2, 2);
      wr(IDX_CONTROL_B, CLK_DIV1);
      repeat (300) @(posedge clk_i);
      wr(IDX_CONTROL_B, CLK_STOP);
      rdc(IDX_IRQ_FLAGS, 7, 7);
      gie <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({irq_a, irq_b, irq_v}, 7, 7);
      wr(IDX_IRQ_MASK, 2);
      repeat (2) @(posedge clk_i);
      chk({irq_a, irq_b, irq_v}, 4, 4);
      wr(IDX_IRQ_MASK, 0);
      @(posedge clk_i);
      chk({irq_a, irq_b, irq_v}, 0, 0);
      wr(IDX_IRQ_MASK, 2);
      gie <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({irq_a, irq_b, irq_v}, 0, 0);
      ack_b <= 1'b1;
      @(posedge clk_i);
      ack_b <= 1'b0;
      rdc(IDX_IRQ_FLAGS, 3, 3);
      wr(IDX_IRQ_FLAGS, 0);
      rdc(IDX_IRQ_FLAGS, 3, 3);
      wr(IDX_IRQ_FLAGS, 2);
      rdc(IDX_IRQ_FLAGS, 1, 1);
      ack_v <= 1'b1;
      @(posedge clk_i);
      ack_v <= 1'b0;
      rdc(IDX_IRQ_FLAGS, 0, 0);
      wr(IDX_COMPARE_A, 8'h20);
      wr(IDX_COUNT, 8'h20);
      wr(IDX_CONTROL_B, CLK_DIV1);
      repeat (64) @(posedge clk_i);
      wr(IDX_CONTROL_B, CLK_STOP);
      rdc(IDX_IRQ_FLAGS, 0, 0);
      rdc(IDX_COUNT, 8'h5E, 8'h68);
      wr(IDX_CONTROL_A, MODE_CLEAR);
      wr(IDX_COMPARE_A, 8'h0F);
      wr(IDX_COUNT, 0);
      wr(IDX_CONTROL_B, CLK_DIV1);
      repeat (300) @(posedge clk_i);
      wr(IDX_CONTROL_B, CLK_STOP);
      rdc(IDX_COUNT, 0, 8'h0F);
      rdc(IDX_IRQ_FLAGS, 2, 2);
      ack_a <= 1'b1;
      @(posedge clk_i);
      ack_a <= 1'b0;
      rdc(IDX_IRQ_FLAGS, 0, 0);
      wr(IDX_COUNT, 5);
      for (int i = 0; i < 5; i++) begin
         wr(IDX_CONTROL_A, {fc[i], fc[i], 4'h2});
         wr(IDX_CONTROL_B, 8'hC0);
         repeat (2) @(posedge clk_i);
         chk({wa, wb, wa_en, wb_en}, {fe[i], fe[i], 2'h3}, {fe[i], fe[i], 2'h3});
      end
      rdc(IDX_CONTROL_B, 0, 0);
      rdc(IDX_IRQ_FLAGS, 0, 0);
      rdc(IDX_COUNT, 5, 5);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CONTROL_A, 0);
         wr(IDX_COMPARE_A, pca[i]);
         wr(IDX_COMPARE_B, pcb[i]);
         wr(IDX_CONTROL_A, pma[i]);
         wr(IDX_CONTROL_B, pmb[i]);
         repeat (2 * per[i] + 256) @(posedge clk_i);
         wr(IDX_IRQ_FLAGS, 7);
         cnt = 0;
         repeat (per[i]) begin
            @(posedge clk_i);
            cnt += (wb === 1'b1);
         end
         chk(cnt, ex[i] - 3, ex[i] + 3);
         rdc(IDX_IRQ_FLAGS, 7, 7);
      end
      wr(IDX_CONTROL_A, 0);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CONTROL_B, i + 2);
         wr(IDX_COUNT, 0);
         repeat (6 * dv[i]) @(posedge clk_i);
         wr(IDX_CONTROL_B, CLK_STOP);
         rdc(IDX_COUNT, 6, 7);
      end
      cnt = rd;
      repeat (100) @(posedge clk_i);
      rdc(IDX_COUNT, cnt, cnt);
      for (int i = 0; i < 2; i++) begin
         wr(IDX_CONTROL_B, (i == 0) ? CLK_EXT_RISE : CLK_EXT_FALL);
         wr(IDX_COUNT, 0);
         repeat (5) begin
            pin <= 1'b1;
            repeat (4 + ($random(seed) & 3)) @(posedge clk_i);
            pin <= 1'b0;
            repeat (4 + ($random(seed) & 3)) @(posedge clk_i);
         end
         wr(IDX_CONTROL_B, CLK_STOP);
         rdc(IDX_COUNT, 5, 5);
      end
      print_verdict();
   end
endmodule
